// [logic/posf_defines.svh]
// Code-group and GMII octet constants for the ordered-set framer.
// Assumes code groups are 8-bit values with a separate control flag.
`ifndef POSF_DEFINES_SVH
`define POSF_DEFINES_SVH
// Control code groups (flag set)
`define POSF_K28_5 8'hBC
`define POSF_K23_7 8'hF7
`define POSF_K27_7 8'hFB
`define POSF_K29_7 8'hFD
`define POSF_K30_7 8'hFE
// Data code groups (flag clear)
`define POSF_D21_5 8'hB5
`define POSF_D2_2  8'h42
`define POSF_D5_6  8'hC5
`define POSF_D16_2 8'h50
// GMII octets
`define POSF_PREAMBLE 8'h55
`define POSF_EXT_CODE 8'h0F
`endif

// [logic/posf_pkg.sv]
// Types for the ordered-set framer.
// Assumes posf_defines.svh carries all numeric constants.
package posf_pkg;
    typedef enum logic [2:0] {
        POSF_TX_IDLE_K,
        POSF_TX_IDLE_D,
        POSF_TX_DATA,
        POSF_TX_EXT1,
        POSF_TX_EXT2,
        POSF_TX_CFG
    } posf_tx_state_t;
endpackage

// [logic/posf_framer.sv]
// Ordered-set framer: GMII transmit to code groups and code groups to GMII receive.
// Assumes an external 8B/10B coder supplies running disparity and decodes the line.
`include "posf_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module posf_framer (
    // Clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    // GMII transmit from MAC
    input  wire logic [7:0] gmii_txd_i,
    input  wire logic       gmii_tx_en_i,
    input  wire logic       gmii_tx_er_i,
    // Configuration sending control and running disparity
    input  wire logic       cfg_send_i,
    input  wire logic [15:0] cfg_word_i,
    input  wire logic       rd_pos_i,
    // Code-group transmit to line coder
    output logic [7:0]      tx_cg_o,
    output logic            tx_ctrl_o,
    // Code-group receive from line decoder
    input  wire logic [7:0] rx_cg_i,
    input  wire logic       rx_ctrl_i,
    // GMII receive to MAC
    output logic [7:0]      gmii_rxd_o,
    output logic            gmii_rx_dv_o,
    output logic            gmii_rx_er_o
);

    // Transmit state
    posf_pkg::posf_tx_state_t st_q, st_d;
    logic [7:0] tx_cg_q, tx_cg_d;
    logic       tx_ctrl_q, tx_ctrl_d;
    logic [1:0] cfg_idx_q, cfg_idx_d;
    logic       cfg_alt_q, cfg_alt_d;
    logic       odd_q, odd_d;
    logic       post_frame_q, post_frame_d;

    // Receive state
    logic       rx_in_frame_q, rx_in_frame_d;
    logic       rx_seen_t_q, rx_seen_t_d;
    logic       rx_seen_r_q, rx_seen_r_d;
    logic [7:0] rxd_q, rxd_d;
    logic       rx_dv_q, rx_dv_d;
    logic       rx_er_q, rx_er_d;

    // Is this a given control code group
    function automatic logic is_k(input logic ctrl, input logic [7:0] cg, input logic [7:0] k);
        is_k = ctrl && (cg == k);
    endfunction

    // Transmit next-state logic
    always_comb begin
        st_d         = st_q;
        tx_cg_d      = tx_cg_q;
        tx_ctrl_d    = tx_ctrl_q;
        cfg_idx_d    = cfg_idx_q;
        cfg_alt_d    = cfg_alt_q;
        odd_d        = ~odd_q;
        post_frame_d = post_frame_q;
        unique case (st_q)
            posf_pkg::POSF_TX_IDLE_K: begin
                if (gmii_tx_en_i) begin
                    // Even rise: start in place of first preamble octet
                    tx_cg_d   = `POSF_K27_7;
                    tx_ctrl_d = 1'b1;
                    st_d      = posf_pkg::POSF_TX_DATA;
                end else if (cfg_send_i) begin
                    tx_cg_d   = `POSF_K28_5;
                    tx_ctrl_d = 1'b1;
                    cfg_idx_d = 2'h1;
                    st_d      = posf_pkg::POSF_TX_CFG;
                end else begin
                    tx_cg_d   = `POSF_K28_5;
                    tx_ctrl_d = 1'b1;
                    st_d      = posf_pkg::POSF_TX_IDLE_D;
                end
            end
            posf_pkg::POSF_TX_IDLE_D: begin
                // Correcting idle only for the first one after a frame
                tx_ctrl_d = 1'b0;
                if (post_frame_q && rd_pos_i) begin
                    tx_cg_d = `POSF_D5_6;
                end else begin
                    tx_cg_d = `POSF_D16_2;
                end
                post_frame_d = 1'b0;
                // Odd rise: the idle's D16.2 or D5.6 eats first preamble octet, start follows
                st_d = posf_pkg::POSF_TX_IDLE_K;
            end
            posf_pkg::POSF_TX_DATA: begin
                if (gmii_tx_en_i) begin
                    tx_cg_d   = gmii_tx_er_i ? `POSF_K30_7 : gmii_txd_i;
                    tx_ctrl_d = gmii_tx_er_i;
                end else begin
                    tx_cg_d   = `POSF_K29_7;
                    tx_ctrl_d = 1'b1;
                    // End on even needs one extend, on odd two
                    // odd_q is the parity of the group now shown; the end code takes the other slot
                    st_d = odd_q ? posf_pkg::POSF_TX_EXT1 : posf_pkg::POSF_TX_EXT2;
                end
            end
            posf_pkg::POSF_TX_EXT2: begin
                tx_cg_d   = `POSF_K23_7;
                tx_ctrl_d = 1'b1;
                st_d      = posf_pkg::POSF_TX_EXT1;
            end
            posf_pkg::POSF_TX_EXT1: begin
                tx_cg_d      = `POSF_K23_7;
                tx_ctrl_d    = 1'b1;
                post_frame_d = 1'b1;
                st_d         = posf_pkg::POSF_TX_IDLE_K;
            end
            posf_pkg::POSF_TX_CFG: begin
                // Second group names the set, last two carry the word
                tx_ctrl_d = 1'b0;
                unique case (cfg_idx_q)
                    2'h1:    tx_cg_d = cfg_alt_q ? `POSF_D2_2 : `POSF_D21_5;
                    2'h2:    tx_cg_d = cfg_word_i[7:0];
                    default: tx_cg_d = cfg_word_i[15:8];
                endcase
                cfg_idx_d = cfg_idx_q + 2'h1;
                if (cfg_idx_q == 2'h3) begin
                    cfg_alt_d = ~cfg_alt_q;
                    st_d      = posf_pkg::POSF_TX_IDLE_K;
                end
            end
            default: st_d = posf_pkg::POSF_TX_IDLE_K;
        endcase
    end

    // Transmit registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // Comma shown in the even slot, so the idle's data group comes next
            st_q         <= posf_pkg::POSF_TX_IDLE_D;
            tx_cg_q      <= `POSF_K28_5;
            tx_ctrl_q    <= 1'b1;
            cfg_idx_q    <= 2'h0;
            cfg_alt_q    <= 1'b0;
            odd_q        <= 1'b0;
            post_frame_q <= 1'b0;
        end else if (ce_i) begin
            st_q         <= st_d;
            tx_cg_q      <= tx_cg_d;
            tx_ctrl_q    <= tx_ctrl_d;
            cfg_idx_q    <= cfg_idx_d;
            cfg_alt_q    <= cfg_alt_d;
            odd_q        <= odd_d;
            post_frame_q <= post_frame_d;
        end
    end

    assign tx_cg_o   = tx_cg_q;
    assign tx_ctrl_o = tx_ctrl_q;

    // Receive next-state logic
    always_comb begin
        rx_in_frame_d = rx_in_frame_q;
        rx_seen_t_d   = 1'b0;
        rx_seen_r_d   = 1'b0;
        rxd_d         = 8'h00;
        rx_dv_d       = 1'b0;
        rx_er_d       = 1'b0;
        if (is_k(rx_ctrl_i, rx_cg_i, `POSF_K27_7)) begin
            // Start becomes one preamble octet; nothing added before it
            rx_in_frame_d = 1'b1;
            rxd_d         = `POSF_PREAMBLE;
            rx_dv_d       = 1'b1;
        end else if (rx_in_frame_q) begin
            if (is_k(rx_ctrl_i, rx_cg_i, `POSF_K29_7)) begin
                rx_in_frame_d = 1'b0;
                rx_seen_t_d   = 1'b1;
            end else if (is_k(rx_ctrl_i, rx_cg_i, `POSF_K30_7)) begin
                rx_dv_d = 1'b1;
                rx_er_d = 1'b1;
            end else begin
                rxd_d   = rx_cg_i;
                rx_dv_d = 1'b1;
            end
        end else if (is_k(rx_ctrl_i, rx_cg_i, `POSF_K23_7) && (rx_seen_t_q || rx_seen_r_q)) begin
            // End then two extends: frame extension, full duplex too
            rx_seen_r_d = rx_seen_t_q;
            if (rx_seen_r_q) begin
                rxd_d   = `POSF_EXT_CODE;
                rx_er_d = 1'b1;
            end
        end
    end

    // Receive registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_in_frame_q <= 1'b0;
            rx_seen_t_q   <= 1'b0;
            rx_seen_r_q   <= 1'b0;
            rxd_q         <= 8'h00;
            rx_dv_q       <= 1'b0;
            rx_er_q       <= 1'b0;
        end else if (ce_i) begin
            rx_in_frame_q <= rx_in_frame_d;
            rx_seen_t_q   <= rx_seen_t_d;
            rx_seen_r_q   <= rx_seen_r_d;
            rxd_q         <= rxd_d;
            rx_dv_q       <= rx_dv_d;
            rx_er_q       <= rx_er_d;
        end
    end

    assign gmii_rxd_o   = rxd_q;
    assign gmii_rx_dv_o = rx_dv_q;
    assign gmii_rx_er_o = rx_er_q;

endmodule
`default_nettype wire

// [verification/posf_framer_sva.sv]
// Port checker for the ordered-set framer.
// Assumes ce_i stays high while it watches.
`include "posf_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module posf_framer_sva (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        srst_i,
    // Transmit side
    input wire logic        gmii_tx_en_i,
    input wire logic        gmii_tx_er_i,
    input wire logic [15:0] cfg_word_i,
    input wire logic [7:0]  tx_cg_o,
    input wire logic        tx_ctrl_o,
    // Receive side
    input wire logic [7:0]  rx_cg_i,
    input wire logic        rx_ctrl_i,
    input wire logic [7:0]  gmii_rxd_o,
    input wire logic        gmii_rx_dv_o,
    input wire logic        gmii_rx_er_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Control code group flags
    wire logic t_com = tx_ctrl_o && tx_cg_o == `POSF_K28_5;
    wire logic t_sop = tx_ctrl_o && tx_cg_o == `POSF_K27_7;
    wire logic t_end = tx_ctrl_o && tx_cg_o == `POSF_K29_7;
    wire logic t_ext = tx_ctrl_o && tx_cg_o == `POSF_K23_7;
    wire logic r_sop = rx_ctrl_i && rx_cg_i == `POSF_K27_7;
    wire logic r_end = rx_ctrl_i && rx_cg_i == `POSF_K29_7;
    wire logic r_ext = rx_ctrl_i && rx_cg_i == `POSF_K23_7;
    // Framing relations
    a_eop_on_fall: assert property ($fell(gmii_tx_en_i) |=> t_end)
        else $error("end code missing after enable fell");
    a_ext_after_eop: assert property (t_end |=> t_ext ##1 (t_ext || t_com))
        else $error("bad extend after end code");
    a_idle_after_ext: assert property (t_ext && $past(t_ext) |=> t_com)
        else $error("comma missing after two extends");
    a_comma_then_data: assert property (t_com |=> !tx_ctrl_o)
        else $error("comma not followed by data group");
    a_sop_after_data: assert property (t_sop |-> !$past(tx_ctrl_o))
        else $error("start code not after complete idle");
    a_err_code: assert property (gmii_tx_en_i && gmii_tx_er_i && $past(gmii_tx_en_i, 2)
        |=> tx_ctrl_o && tx_cg_o == `POSF_K30_7)
        else $error("error code missing");
    a_cfg_word: assert property (t_com ##1 (!tx_ctrl_o && tx_cg_o == `POSF_D21_5)
        |=> tx_cg_o == cfg_word_i[7:0] ##1 tx_cg_o == cfg_word_i[15:8])
        else $error("config word groups wrong");
    a_rx_sop: assert property (r_sop |=> gmii_rx_dv_o && gmii_rxd_o == `POSF_PREAMBLE)
        else $error("start code not turned into preamble");
    a_rx_ext: assert property (r_ext && $past(r_ext) && $past(r_end, 2)
        |=> gmii_rx_er_o && !gmii_rx_dv_o && gmii_rxd_o == `POSF_EXT_CODE)
        else $error("frame extension not signalled");
    // Main scenarios
    c_sop: cover property (t_sop);
    c_two_ext: cover property (t_end ##1 t_ext ##1 t_ext);
    c_err: cover property (gmii_tx_en_i && gmii_tx_er_i);
endmodule
bind posf_framer posf_framer_sva posf_framer_sva_inst (.clk_i, .srst_i, .gmii_tx_en_i, .gmii_tx_er_i,
    .cfg_word_i, .tx_cg_o, .tx_ctrl_o, .rx_cg_i, .rx_ctrl_i, .gmii_rxd_o, .gmii_rx_dv_o, .gmii_rx_er_o);
`default_nettype wire

// [verification/posf_line_loop.sv]
// Line partner: transceiver looping code groups back.
// Assumes one shared byte clock.
`timescale 1ns/100ps
`default_nettype none
module posf_line_loop (
    // Clock
    input  wire logic       clk_i,
    // From framer transmit
    input  wire logic [7:0] tx_cg_i,
    input  wire logic       tx_ctrl_i,
    // To framer receive
    output logic [7:0]      rx_cg_o,
    output logic            rx_ctrl_o
);
    // One cycle of line delay
    always_ff @(posedge clk_i) begin
        rx_cg_o   <= tx_cg_i;
        rx_ctrl_o <= tx_ctrl_i;
    end
endmodule
`default_nettype wire

// [verification/posf_framer_tb.sv]
// Bench for the ordered-set framer, line looped back.
// Assumes output follows sampled input by one edge.
`timescale 1ns/100ps
`default_nettype none
module posf_framer_tb;
    // Stimulus, capture and counters
    logic        clk_i = 0, srst_i = 1, gmii_tx_en_i = 0, gmii_tx_er_i = 0, cfg_send_i = 0, rd_pos_i = 0;
    logic [7:0]  gmii_txd_i = 8'h00, tx_cg_o, rx_cg_i, gmii_rxd_o;
    logic [15:0] cfg_word_i = 16'h3C9A;
    logic        tx_ctrl_o, rx_ctrl_i, gmii_rx_dv_o, gmii_rx_er_o;
    logic [8:0]  q[$];
    logic [9:0]  rq[$];
    int          failures = 0, total_checks = 0, cycles = 0, na, nb, nc;
    always #5 clk_i = ~clk_i;
    posf_framer posf_framer_inst (.clk_i, .srst_i, .ce_i(1'b1), .gmii_txd_i, .gmii_tx_en_i, .gmii_tx_er_i,
        .cfg_send_i, .cfg_word_i, .rd_pos_i, .tx_cg_o, .tx_ctrl_o, .rx_cg_i, .rx_ctrl_i, .gmii_rxd_o,
        .gmii_rx_dv_o, .gmii_rx_er_o);
    posf_line_loop posf_line_loop_inst (.clk_i, .tx_cg_i(tx_cg_o), .tx_ctrl_i(tx_ctrl_o),
        .rx_cg_o(rx_cg_i), .rx_ctrl_o(rx_ctrl_i));
    // Stream capture and run ceiling
    always @(posedge clk_i) begin
        q.push_back({tx_ctrl_o, tx_cg_o});
        rq.push_back({gmii_rx_er_o, gmii_rx_dv_o, gmii_rxd_o});
        cycles++;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One frame at a chosen slot; returns preamble groups sent after start
    task automatic frame(input int len, input bit odd, input bit err, input bit rp, output int np);
        int f = 1, t, r, n = 0, x = 0, v = 0;
        q = {};
        rq = {};
        rd_pos_i = rp;
        @(posedge clk_i iff (tx_ctrl_o && tx_cg_o == 8'hBC));
        @(negedge clk_i);
        if (odd)
            @(negedge clk_i);
        for (int i = 0; i < len + 8; i++) begin
            gmii_tx_en_i = 1;
            gmii_txd_i = i < 7 ? 8'h55 : i == 7 ? 8'hD5 : 8'(i);
            gmii_tx_er_i = err && i == 10;
            @(negedge clk_i);
        end
        gmii_tx_en_i = 0;
        gmii_tx_er_i = 0;
        repeat (12) @(negedge clk_i);
        while (f < q.size() && q[f] != 9'h1FB) f++;
        chk("pre_sop", 9'h000, {8'h00, q[f - 1][8]});
        np = 0;
        while (q[f + 1 + np] == 9'h055) np++;
        for (int i = 7; i < len + 8; i++)
            chk("octet", (err && i == 10) ? 9'h1FE : {1'b0, i == 7 ? 8'hD5 : 8'(i)}, q[f + np + i - 6]);
        t = f + np + len + 2;
        chk("eop", 9'h1FD, q[t]);
        r = (t - f) % 2 ? 2 : 1;
        for (int i = 1; i <= r; i++)
            chk("ext", 9'h1F7, q[t + i]);
        chk("comma", 9'h1BC, q[t + r + 1]);
        chk("idle", rp ? 9'h0C5 : 9'h050, q[t + r + 2]);
        foreach (rq[k]) begin
            n += rq[k] == 10'h155;
            x += rq[k] == 10'h20F;
            v += rq[k] == 10'h300;
        end
        chk("rx_pre", 9'(np + 1), 9'(n));
        chk("rx_ext", 9'(r == 2), 9'(x));
        chk("rx_err", 9'(err), 9'(v));
    endtask
    task automatic config_sets();
        logic [8:0] ex [8] = '{9'h1BC, 9'h0B5, 9'h09A, 9'h03C, 9'h1BC, 9'h042, 9'h09A, 9'h03C};
        int f = 1;
        q = {};
        cfg_send_i = 1;
        repeat (24) @(negedge clk_i);
        while (f < q.size() && q[f] != 9'h0B5) f++;
        for (int i = 0; i < 8; i++)
            chk("cfg", ex[i], q[f - 1 + i]);
        cfg_send_i = 0;
    endtask
    task test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        srst_i = 0;
        frame(4, 0, 0, 0, na);
        frame(4, 1, 1, 1, nb);
        chk("pre_split", 9'h00B, 9'(na + nb));
        frame(7, 0, 1, 0, nc);
        config_sets();
        test_done();
    end
endmodule
`default_nettype wire
